/* File: rtl/sjtp_pkg.sv */
// Constants and types for the memory test access port.
// Assumes a single system clock that oversamples the test clock pin.
package sjtp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int DR_W = 32;

  // ----------------------------------------------------------------
  // Instruction codes and capture values
  // ----------------------------------------------------------------
  // Every code other than the identification code selects the bypass bit
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam logic IR_CAPTURE_MSB = 1'h0;
  localparam logic BYPASS_CAPTURE = 1'h0;
  // Identification value is arbitrary; bit 0 stays set as the standard asks
  localparam logic [DR_W-1:0] ID_CODE = 32'h0A5A_5001;

  // ----------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;
  localparam logic [2:0] TMS_ONES_RST = 3'h0;
  localparam int TLR_BIT = 0;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR = 16'h8000
  } sjtp_state_t;

  // ----------------------------------------------------------------
  // Carriers and state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic tms_undrv;
    logic tdi_undrv;
  } sjtp_pins_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
  } sjtp_sample_t;

  typedef struct packed {
    sjtp_pins_t s1;
    sjtp_pins_t s2;
    logic tck_d;
  } sjtp_sync_st_t;

  typedef struct packed {
    sjtp_state_t state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sr;
    logic [DR_W-1:0] dr_sr;
    logic tdo;
    logic tdo_oe;
    logic [2:0] tms_ones;
  } sjtp_tap_st_t;

  // Idle pins read high through their pull-ups
  localparam sjtp_sync_st_t SYNC_RST = '1;
  localparam sjtp_tap_st_t TAP_RST = '{
    state: ST_TLR,
    ir: IR_IDCODE,
    ir_sr: IR_IDCODE,
    dr_sr: '0,
    tdo: 1'h0,
    tdo_oe: 1'h0,
    tms_ones: TMS_ONES_RST
  };

endpackage : sjtp_pkg

/* File: rtl/sjtp_sync.sv */
// Pin synchroniser and test clock edge finder.
// Assumes the system clock runs well above the test clock rate.
`timescale 1ns/1ps
`default_nettype none
module sjtp_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire sjtp_pkg::sjtp_pins_t pins_i,
  // Sampled view
  output var sjtp_pkg::sjtp_sample_t sample_o
);

  sjtp_pkg::sjtp_sync_st_t sync_reg;
  sjtp_pkg::sjtp_sync_st_t sync_next;

  // ----------------------------------------------------------------
  // Two stages, then a delayed copy of the clock for edges
  // ----------------------------------------------------------------
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = pins_i;
    sync_next.s2 = sync_reg.s1;
    sync_next.tck_d = sync_reg.s2.tck;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_reg <= sjtp_pkg::SYNC_RST;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Data pins travel with the clock, so they line up with its edge
  always_comb begin
    sample_o.rise = sync_reg.s2.tck & ~sync_reg.tck_d;
    sample_o.fall = ~sync_reg.s2.tck & sync_reg.tck_d;
    sample_o.tms = sync_reg.s2.tms | sync_reg.s2.tms_undrv;
    sample_o.tdi = sync_reg.s2.tdi | sync_reg.s2.tdi_undrv;
  end

endmodule : sjtp_sync
`default_nettype wire

/* File: rtl/sjtp_tap.sv */
// Test access port controller of the memory, oversampled by clk_i.
// Assumes pins arrive unsynchronised; tdo is resolved outside from tdo_oe_o.
`timescale 1ns/1ps
`default_nettype none
module sjtp_tap (
  // Clock and power-up reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Test pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  // Pad keeper flags: pin left floating
  input wire logic tms_undrv_i,
  input wire logic tdi_undrv_i,
  // Serial output pin
  output logic tdo_o,
  output logic tdo_oe_o,
  // Status toward the memory core
  output logic [sjtp_pkg::IR_W-1:0] instr_o,
  output logic tlr_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic sjtp_pkg::sjtp_state_t tap_next(
    input sjtp_pkg::sjtp_state_t s,
    input logic tms
  );
    sjtp_pkg::sjtp_state_t r;
    unique case (s)
      sjtp_pkg::ST_TLR: r = tms ? sjtp_pkg::ST_TLR : sjtp_pkg::ST_RTI;
      sjtp_pkg::ST_RTI: r = tms ? sjtp_pkg::ST_SEL_DR : sjtp_pkg::ST_RTI;
      sjtp_pkg::ST_SEL_DR: r = tms ? sjtp_pkg::ST_SEL_IR : sjtp_pkg::ST_CAP_DR;
      sjtp_pkg::ST_CAP_DR: r = tms ? sjtp_pkg::ST_EX1_DR : sjtp_pkg::ST_SH_DR;
      sjtp_pkg::ST_SH_DR: r = tms ? sjtp_pkg::ST_EX1_DR : sjtp_pkg::ST_SH_DR;
      sjtp_pkg::ST_EX1_DR: r = tms ? sjtp_pkg::ST_UP_DR : sjtp_pkg::ST_PA_DR;
      sjtp_pkg::ST_PA_DR: r = tms ? sjtp_pkg::ST_EX2_DR : sjtp_pkg::ST_PA_DR;
      sjtp_pkg::ST_EX2_DR: r = tms ? sjtp_pkg::ST_UP_DR : sjtp_pkg::ST_SH_DR;
      sjtp_pkg::ST_UP_DR: r = tms ? sjtp_pkg::ST_SEL_DR : sjtp_pkg::ST_RTI;
      sjtp_pkg::ST_SEL_IR: r = tms ? sjtp_pkg::ST_TLR : sjtp_pkg::ST_CAP_IR;
      sjtp_pkg::ST_CAP_IR: r = tms ? sjtp_pkg::ST_EX1_IR : sjtp_pkg::ST_SH_IR;
      sjtp_pkg::ST_SH_IR: r = tms ? sjtp_pkg::ST_EX1_IR : sjtp_pkg::ST_SH_IR;
      sjtp_pkg::ST_EX1_IR: r = tms ? sjtp_pkg::ST_UP_IR : sjtp_pkg::ST_PA_IR;
      sjtp_pkg::ST_PA_IR: r = tms ? sjtp_pkg::ST_EX2_IR : sjtp_pkg::ST_PA_IR;
      sjtp_pkg::ST_EX2_IR: r = tms ? sjtp_pkg::ST_UP_IR : sjtp_pkg::ST_SH_IR;
      sjtp_pkg::ST_UP_IR: r = tms ? sjtp_pkg::ST_SEL_DR : sjtp_pkg::ST_RTI;
      // Corrupt one-hot code falls back to reset
      default: r = sjtp_pkg::ST_TLR;
    endcase
    return r;
  endfunction : tap_next

  function automatic logic is_shift(input sjtp_pkg::sjtp_state_t s);
    return (s == sjtp_pkg::ST_SH_IR) || (s == sjtp_pkg::ST_SH_DR);
  endfunction : is_shift

  function automatic logic id_selected(input logic [sjtp_pkg::IR_W-1:0] ir);
    return ir == sjtp_pkg::IR_IDCODE;
  endfunction : id_selected

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  sjtp_pkg::sjtp_pins_t pins;
  sjtp_pkg::sjtp_sample_t smp;

  always_comb begin
    pins.tck = tck_i;
    pins.tms = tms_i;
    pins.tdi = tdi_i;
    pins.tms_undrv = tms_undrv_i;
    pins.tdi_undrv = tdi_undrv_i;
  end

  // Settled pins rely on the far side moving them after the falling edge
  sjtp_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins),
    .sample_o(smp)
  );

  // ----------------------------------------------------------------
  // Controller and serial registers
  // ----------------------------------------------------------------
  sjtp_pkg::sjtp_tap_st_t st_reg;
  sjtp_pkg::sjtp_tap_st_t st_next;

  always_comb begin
    st_next = st_reg;
    // Rising edge: all capture, shift and update work
    if (smp.rise) begin
      st_next.state = tap_next(st_reg.state, smp.tms);
      if (!smp.tms) begin
        st_next.tms_ones = sjtp_pkg::TMS_ONES_RST;
      end else if (st_reg.tms_ones != sjtp_pkg::TMS_RESET_EDGES) begin
        st_next.tms_ones = 3'(st_reg.tms_ones + 3'h1);
      end
      unique case (st_reg.state)
        sjtp_pkg::ST_CAP_IR: begin
          st_next.ir_sr = {sjtp_pkg::IR_CAPTURE_MSB, sjtp_pkg::IR_CAPTURE_PAT};
        end
        sjtp_pkg::ST_SH_IR: begin
          st_next.ir_sr = {smp.tdi, st_reg.ir_sr[sjtp_pkg::IR_W-1:1]};
        end
        sjtp_pkg::ST_UP_IR: begin
          st_next.ir = st_reg.ir_sr;
        end
        sjtp_pkg::ST_CAP_DR: begin
          if (id_selected(st_reg.ir)) begin
            st_next.dr_sr = sjtp_pkg::ID_CODE;
          end else begin
            st_next.dr_sr = {st_reg.dr_sr[sjtp_pkg::DR_W-1:1], sjtp_pkg::BYPASS_CAPTURE};
          end
        end
        sjtp_pkg::ST_SH_DR: begin
          if (id_selected(st_reg.ir)) begin
            st_next.dr_sr = {smp.tdi, st_reg.dr_sr[sjtp_pkg::DR_W-1:1]};
          end else begin
            // Only bit 0 is the bypass cell
            st_next.dr_sr = {st_reg.dr_sr[sjtp_pkg::DR_W-1:1], smp.tdi};
          end
        end
        default: begin
        end
      endcase
      // Reset state also restores the default instruction
      if (st_next.state == sjtp_pkg::ST_TLR) begin
        st_next.ir = sjtp_pkg::IR_IDCODE;
      end
    end
    // Falling edge: launch the serial output and its enable
    if (smp.fall) begin
      st_next.tdo_oe = is_shift(st_reg.state);
      if (st_reg.state == sjtp_pkg::ST_SH_IR) begin
        st_next.tdo = st_reg.ir_sr[0];
      end else begin
        st_next.tdo = st_reg.dr_sr[0];
      end
    end
  end

  // Power-up reset only; there is deliberately no test reset pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= sjtp_pkg::TAP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tdo_o = st_reg.tdo;
  assign tdo_oe_o = st_reg.tdo_oe;
  assign instr_o = st_reg.ir;
  assign tlr_o = st_reg.state[sjtp_pkg::TLR_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence fall_in_shift;
    smp.fall && is_shift(st_reg.state);
  endsequence

  sequence fall_in_shift_ir;
    smp.fall && (st_reg.state == sjtp_pkg::ST_SH_IR);
  endsequence

  sequence fall_in_shift_dr;
    smp.fall && (st_reg.state == sjtp_pkg::ST_SH_DR);
  endsequence

  sequence rise_in_cap_ir;
    smp.rise && (st_reg.state == sjtp_pkg::ST_CAP_IR);
  endsequence

  sequence rise_in_shift_ir;
    smp.rise && (st_reg.state == sjtp_pkg::ST_SH_IR);
  endsequence

  sequence rise_in_update_ir;
    smp.rise && (st_reg.state == sjtp_pkg::ST_UP_IR);
  endsequence

  // Only Update-IR and the way into reset may touch the instruction
  sequence rise_keeps_instr;
    smp.rise && (st_reg.state != sjtp_pkg::ST_UP_IR) && (st_reg.state != sjtp_pkg::ST_SEL_IR);
  endsequence

  sequence rise_in_cap_id;
    smp.rise && (st_reg.state == sjtp_pkg::ST_CAP_DR) && id_selected(st_reg.ir);
  endsequence

  sequence rise_in_id_shift;
    smp.rise && (st_reg.state == sjtp_pkg::ST_SH_DR) && id_selected(st_reg.ir);
  endsequence

  sequence rise_in_bypass_shift;
    smp.rise && (st_reg.state == sjtp_pkg::ST_SH_DR) && !id_selected(st_reg.ir);
  endsequence

  sequence rise_tms_low;
    smp.rise && !smp.tms;
  endsequence

  sequence rise_tms_high;
    smp.rise && smp.tms;
  endsequence

  five_ones_a: assert property (
    (st_reg.tms_ones == sjtp_pkg::TMS_RESET_EDGES) |-> (st_reg.state == sjtp_pkg::ST_TLR)
  ) else $error("five high mode edges did not reach reset state");

  tms_clear_a: assert property (
    rise_tms_low |=> (st_reg.tms_ones == sjtp_pkg::TMS_ONES_RST)
  ) else $error("low mode select did not clear the run of ones");

  tlr_stay_a: assert property (
    rise_tms_high ##0 (st_reg.state == sjtp_pkg::ST_TLR) |=> tlr_o
  ) else $error("reset state left with mode select high");

  tlr_leave_a: assert property (
    rise_tms_low ##0 (st_reg.state == sjtp_pkg::ST_TLR) |=> (st_reg.state == sjtp_pkg::ST_RTI)
  ) else $error("reset state not left for idle with mode select low");

  tdo_launch_a: assert property (
    $changed(tdo_o) |-> $past(smp.fall)
  ) else $error("serial output changed without a falling test clock");

  oe_hold_a: assert property (
    !smp.fall |=> $stable(tdo_oe_o)
  ) else $error("output enable changed without a falling test clock");

  tdo_from_ir_a: assert property (
    fall_in_shift_ir |=> (tdo_o == $past(st_reg.ir_sr[0]))
  ) else $error("serial output not fed from the instruction shifter");

  tdo_from_dr_a: assert property (
    fall_in_shift_dr |=> (tdo_o == $past(st_reg.dr_sr[0]))
  ) else $error("serial output not fed from the data shifter");

  tdo_enable_a: assert property (
    fall_in_shift |=> tdo_oe_o
  ) else $error("serial output not enabled in a shift state");

  tdo_float_a: assert property (
    (smp.fall && !is_shift(st_reg.state)) |=> !tdo_oe_o
  ) else $error("serial output enabled outside the shift states");

  ir_capture_a: assert property (
    rise_in_cap_ir |=> (st_reg.ir_sr[1:0] == sjtp_pkg::IR_CAPTURE_PAT)
  ) else $error("instruction capture pattern wrong");

  ir_shift_a: assert property (
    rise_in_shift_ir |=>
      (st_reg.ir_sr == {$past(smp.tdi), $past(st_reg.ir_sr[sjtp_pkg::IR_W-1:1])})
  ) else $error("instruction shifter did not take the data input");

  ir_update_a: assert property (
    rise_in_update_ir |=> (instr_o == $past(st_reg.ir_sr))
  ) else $error("instruction not updated from the shifter");

  instr_hold_a: assert property (
    rise_keeps_instr |=> $stable(instr_o)
  ) else $error("instruction changed outside update or reset");

  reset_instr_a: assert property (
    (st_reg.state == sjtp_pkg::ST_TLR) |-> (st_reg.ir == sjtp_pkg::IR_IDCODE)
  ) else $error("reset state without identification instruction");

  id_capture_a: assert property (
    rise_in_cap_id |=> (st_reg.dr_sr == sjtp_pkg::ID_CODE)
  ) else $error("identification value not captured");

  id_shift_a: assert property (
    rise_in_id_shift |=>
      (st_reg.dr_sr == {$past(smp.tdi), $past(st_reg.dr_sr[sjtp_pkg::DR_W-1:1])})
  ) else $error("identification value did not shift toward the output");

  bypass_delay_a: assert property (
    rise_in_bypass_shift |=>
      (st_reg.dr_sr[0] == $past(smp.tdi)) ##0 $stable(st_reg.dr_sr[sjtp_pkg::DR_W-1:1])
  ) else $error("bypass cell did not take the data input");

  idle_quiet_a: assert property (
    !smp.rise |=> ($stable(st_reg.state) && $stable(st_reg.ir) && $stable(st_reg.dr_sr))
  ) else $error("controller moved without a rising test clock");

  powerup_state_a: assert property (
    $rose(rst_n_i) |-> (tlr_o && !tdo_oe_o && (instr_o == sjtp_pkg::IR_IDCODE))
  ) else $error("power-up did not leave the reset state");

endmodule : sjtp_tap
`default_nettype wire

/* File: verification/sjtp_ctrl_model.sv */
// Board test controller model: drives the test pins, watches data out.
// Assumes clk_i is the 40 MHz system clock; one call of step is one test clock.
`timescale 1ns/1ps
`default_nettype none
module sjtp_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Device side
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  // Test pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic tms_undrv_o,
  output logic tdi_undrv_o
);
  logic seen_tdo;
  logic seen_oe;
  initial begin
    tck_o = 1'h1;
    tms_o = 1'h1;
    tdi_o = 1'h1;
    tms_undrv_o = 1'h0;
    tdi_undrv_o = 1'h0;
  end
  task automatic float_pins(input logic f_tms, input logic f_tdi);
    tms_undrv_o = f_tms;
    tdi_undrv_o = f_tdi;
  endtask : float_pins
  // Moves the data pins while the test clock stands still
  task automatic set_data(input logic tms, input logic tdi);
    tms_o = tms;
    tdi_o = tdi;
  endtask : set_data
  // 100 ns low, 100 ns high; clock stands high between calls
  task automatic step(input logic tms, input logic tdi);
    @(negedge clk_i);
    tck_o = 1'h0;
    @(negedge clk_i);
    // Floating pin sits low; only the keeper flag may make it read high
    tms_o = tms_undrv_o ? 1'h0 : tms;
    tdi_o = tdi_undrv_o ? 1'h0 : tdi;
    repeat (3) @(negedge clk_i);
    tck_o = 1'h1;
    repeat (2) @(negedge clk_i);
    seen_tdo = tdo_i;
    seen_oe = tdo_oe_i;
    @(negedge clk_i);
  endtask : step
endmodule : sjtp_ctrl_model
`default_nettype wire

/* File: verification/sjtp_tap_test.sv */
// Self-checking bench of the test access port controller.
// Assumes the controller model steps the test clock at 200 ns.
`timescale 1ns/1ps
`default_nettype none
module sjtp_tap_test;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic tck, tms, tdi, tms_u, tdi_u, tdo, tdo_oe, tlr;
  logic [sjtp_pkg::IR_W-1:0] instr;
  logic [2:0] ir_seen;
  logic [2:0] cur_code;
  logic prev;
  int error_cnt = 0;
  int n_compared = 0;
  int seed;
  always #12.5 clk_i = ~clk_i;
  sjtp_tap uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tms_undrv_i(tms_u), .tdi_undrv_i(tdi_u), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .instr_o(instr), .tlr_o(tlr));
  sjtp_ctrl_model m (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .tms_undrv_o(tms_u), .tdi_undrv_o(tdi_u));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic exp_tdo(input logic [2:0] code, input int i, input logic p);
    return (code === sjtp_pkg::IR_IDCODE) ? sjtp_pkg::ID_CODE[i] : p;
  endfunction : exp_tdo
  task automatic go(input logic [7:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      m.step(bits[i], 1'h1);
    end
  endtask : go
  // Registered status lags a test clock rise by up to 4 clk
  task automatic settle();
    repeat (4) @(negedge clk_i);
  endtask : settle
  // From idle: load code, back to idle
  task automatic load_ir(input logic [2:0] code);
    go(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      m.step(i == 2, code[i]);
      ir_seen[i] = m.seen_tdo;
      check("ir tdo_oe", 1, m.seen_oe);
    end
    check("ir capture", {sjtp_pkg::IR_CAPTURE_MSB, sjtp_pkg::IR_CAPTURE_PAT}, ir_seen);
    go(8'h01, 2);
    settle();
    check("instr", code, instr);
  endtask : load_ir
  // From idle: 32 data shifts with random data in, back to idle
  task automatic shift_dr(input logic [2:0] code);
    logic [31:0] din;
    din = $urandom();
    go(8'h01, 3);
    prev = sjtp_pkg::BYPASS_CAPTURE;
    for (int i = 0; i < 32; i++) begin
      m.step(i == 31, din[i]);
      check("tdo", exp_tdo(code, i, prev), m.seen_tdo);
      check("tdo_oe", 1, m.seen_oe);
      prev = din[i] | tdi_u;
    end
    go(8'h01, 2);
    settle();
    check("tdo_oe idle", 0, tdo_oe);
  endtask : shift_dr
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(50113);
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'h1;
    // Pins wiggle but the test clock never moves
    repeat (20) begin
      @(negedge clk_i);
      m.set_data(1'($urandom()), 1'($urandom()));
    end
    check("tlr", 1, tlr);
    check("instr", sjtp_pkg::IR_IDCODE, instr);
    check("tdo_oe", 0, tdo_oe);
    $display("test power-up done");
    go(8'h00, 1);
    shift_dr(sjtp_pkg::IR_IDCODE);
    $display("test identification done");
    for (int c = 0; c < 12; c++) begin
      cur_code = (c < 8) ? 3'(c) : 3'($urandom_range(7));
      load_ir(cur_code);
      shift_dr(cur_code);
    end
    $display("test instructions done");
    load_ir(3'h6);
    m.float_pins(1'h0, 1'h1);
    shift_dr(3'h6);
    m.float_pins(1'h0, 1'h0);
    $display("test floating data done");
    load_ir(3'h2);
    go(8'h01, 3);
    m.float_pins(1'h1, 1'h0);
    go(8'h00, 4);
    settle();
    check("tlr after 4", 0, tlr);
    go(8'h00, 1);
    settle();
    check("tlr after 5", 1, tlr);
    check("instr preload", sjtp_pkg::IR_IDCODE, instr);
    m.float_pins(1'h0, 1'h0);
    $display("test mode reset done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule : sjtp_tap_test
`default_nettype wire
